// ### cycle_event_pkg.sv
/*
  Shared constants for the link cycle timer and link event logic:
  register offsets, field layouts, flag positions, reset values and timing counts.
  Assumes a single 50 MHz reference clock and a synchronous active-low reset.
*/
`default_nettype none

package cycle_event_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register port geometry and byte offsets
  localparam int unsigned      ADDR_W        = 8;
  localparam int unsigned      DATA_W        = 32;
  localparam logic [7:0]       OFF_GEN_CTRL  = 8'h00;
  localparam logic [7:0]       OFF_EVT_ACK   = 8'h08;
  localparam logic [7:0]       OFF_EVT_ENA   = 8'h0C;
  localparam logic [7:0]       OFF_CYC_TIMER = 8'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // general control fields
  localparam int unsigned      CTRL_W        = 2;
  localparam int unsigned      CTRL_TMR_EN   = 0;
  localparam int unsigned      CTRL_MASTER   = 1;
  localparam logic [1:0]       CTRL_RESET    = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // event flag positions in the acknowledge and enable registers
  localparam int unsigned      EVT_W         = 19;
  localparam int unsigned      EVT_BUSY_ACK  = 0;
  localparam int unsigned      EVT_HDR_ERR   = 1;
  localparam int unsigned      EVT_TCODE_ERR = 2;
  localparam int unsigned      EVT_CYC_TOUT  = 3;
  localparam int unsigned      EVT_SEC_INC   = 4;
  localparam int unsigned      EVT_CYC_START = 5;
  localparam int unsigned      EVT_CYC_DONE  = 6;
  localparam int unsigned      EVT_CYC_PEND  = 7;
  localparam int unsigned      EVT_CYC_LOST  = 8;
  localparam int unsigned      EVT_FAIR_GAP  = 9;
  localparam logic [18:0]      EVT_RESET     = 19'h00000;
  localparam logic [18:0]      ENA_RESET     = 19'h00000;

  ////////////////////////////////////////////////////////////////////////////////
  // cycle timer fields and wrap points
  localparam int unsigned      SEC_HI        = 31;
  localparam int unsigned      SEC_LO        = 25;
  localparam int unsigned      NUM_HI        = 24;
  localparam int unsigned      NUM_LO        = 12;
  localparam int unsigned      OFS_HI        = 11;
  localparam int unsigned      OFS_LO        = 0;
  localparam logic [11:0]      OFFSET_MAX    = 12'hBFF;
  localparam logic [12:0]      NUMBER_MAX    = 13'h1F3F;
  localparam logic [31:0]      TIMER_RESET   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: longest isochronous cycle and rollovers before a cycle is lost
  localparam int unsigned      CLK_KHZ       = 50000;
  localparam int unsigned      CYC_LIMIT_NS  = 125000;
  localparam int unsigned      CYC_LIMIT_CYC = (CYC_LIMIT_NS / 1000) * CLK_KHZ / 1000; // ordered to stay within 32 bits
  localparam int unsigned      TOUT_W        = 16;
  localparam logic [1:0]       LOST_WRAPS    = 2'h2;

endpackage

`default_nettype wire

// ### cycle_time_counter.sv
/*
  Seconds / cycle number / cycle offset counter of the bus cycle timer.
  Assumes run and load come from logic on the same clock; ticks at half ref_clk.
*/
`default_nettype none

module cycle_time_counter
  import cycle_event_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  output logic      [31:0] value,
  output logic             sec_inc,
  output logic             offset_wrap,
  output logic             offset_zero
);

  logic        tick_r;
  logic [6:0]  sec_r;
  logic [12:0] num_r;
  logic [11:0] ofs_r;
  logic        step;
  logic        ofs_end;
  logic        num_end;

  assign step    = run && tick_r;
  assign ofs_end = (ofs_r == OFFSET_MAX);
  assign num_end = (num_r == NUMBER_MAX);
  assign value   = {sec_r, num_r, ofs_r};

  ////////////////////////////////////////////////////////////////////////////////
  // divide by two for the offset tick
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= ~tick_r;
    end
  end

  // counter fields with carry chain
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sec_r <= TIMER_RESET[SEC_HI:SEC_LO];
      num_r <= TIMER_RESET[NUM_HI:NUM_LO];
      ofs_r <= TIMER_RESET[OFS_HI:OFS_LO];
    end else if (load) begin
      sec_r <= load_val[SEC_HI:SEC_LO];
      num_r <= load_val[NUM_HI:NUM_LO];
      ofs_r <= load_val[OFS_HI:OFS_LO];
    end else if (step) begin
      if (ofs_end) begin
        ofs_r <= '0;
        if (num_end) begin
          num_r <= '0;
          sec_r <= sec_r + 7'h01;
        end else begin
          num_r <= num_r + 13'h0001;
        end
      end else begin
        ofs_r <= ofs_r + 12'h001;
      end
    end
  end

  // one-cycle event pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sec_inc     <= 1'b0;
      offset_wrap <= 1'b0;
      offset_zero <= 1'b1; // offset is zero out of reset
    end else begin
      sec_inc     <= !load && step && ofs_end && num_end;
      offset_wrap <= !load && step && ofs_end;
      offset_zero <= (!load && step && ofs_end) || (load && load_val[OFS_HI:OFS_LO] == 12'h000);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_offset_wraps: assert property (!load && step && ofs_end |=> ofs_r == 12'h000 && offset_wrap)
    else $error("cycle offset did not wrap to zero");
  a_timer_holds: assert property (!run && !load |=> $stable(value))
    else $error("cycle timer moved while disabled");

endmodule

`default_nettype wire

// ### link_cycle_timer_and_events.sv
/*
  Link cycle timer and link event flags with their enable mirror and a plain
  register port. Assumes all event inputs are one-cycle pulses from link logic
  on ref_clk (50 MHz); read data appear the cycle after the read strobe.
*/
// Local design decision: the plain strobed port.
// Summary of operation
// - set busy-sent flag when receiver answers busy after its buffer overflowed
// - set header error flag on header CRC error of a possibly local packet
// - set transaction code error flag on invalid code at transmit buffer
// - cycle over 125 us from start to fair gap: flag it, drop cycle master
// - set seconds flag whenever the seconds field advances
// - set cycle started flag on cycle start sent or received
// - set cycle done flag on fair gap after cycle start; writing zero keeps it
// - cycle pending rises when offset becomes zero, holds until cycle ends
// - not cycle master: two rollovers without received cycle start set cycle lost
// - enable register mirrors flags; one lets a flag interrupt, zero blocks it
// - disabled flags are still recorded and readable
// - enable bits 18 down to 0, reset to zero
// - cycle timer counts only while the timer enable control bit is set
// - seconds in bits 31..25, 1 Hz, read/write, reset zero; here about 1.017 Hz from the 25 MHz offset tick
// - cycle number in bits 24..12 at 8 kHz, read/write; here about 8138 Hz, one step per 3072 offset ticks at 25 MHz
// - cycle offset in bits 11..0 at 24.576 MHz, read/write; here it ticks at half ref_clk, 25 MHz
// - set fair gap flag when bus idles for a fair gap
`default_nettype none

module link_cycle_timer_and_events
  import cycle_event_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = CYC_LIMIT_CYC
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rx_busy_ack_sent,
  input  wire logic        rx_header_crc_err,
  input  wire logic        tx_tcode_err,
  input  wire logic        tx_cycle_start_sent,
  input  wire logic        rx_cycle_start_rcvd,
  input  wire logic        bus_fair_gap,
  output logic             link_event_irq,
  output logic             cycle_master_en,
  output logic             cycle_pending
);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  logic [1:0]        ctrl_r;
  logic [1:0]        ctrl_nxt;
  logic [EVT_W-1:0]  ena_r;
  logic [EVT_W-1:0]  flags_r;
  logic [EVT_W-1:0]  flags_nxt;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  logic              cyc_active_r;
  logic [TOUT_W-1:0] tout_cnt_r;
  logic              tout_hit;
  logic [1:0]        lost_cnt_r;
  logic              lost_hit;
  logic              cyc_start;
  logic              cyc_done;
  logic              wr_ctrl;
  logic              wr_ack;
  logic              wr_ena;
  logic              wr_timer;
  logic [31:0]       timer_val;
  logic              sec_inc;
  logic              offset_wrap;
  logic              offset_zero;
  logic [TOUT_W-1:0] tout_limit;

  assign tout_limit = TOUT_W'(TIMEOUT_CYCLES);

  ////////////////////////////////////////////////////////////////////////////////
  // write strobes per register
  assign wr_ctrl  = reg_wr && addr_hit(reg_addr, OFF_GEN_CTRL);
  assign wr_ack   = reg_wr && addr_hit(reg_addr, OFF_EVT_ACK);
  assign wr_ena   = reg_wr && addr_hit(reg_addr, OFF_EVT_ENA);
  assign wr_timer = reg_wr && addr_hit(reg_addr, OFF_CYC_TIMER);

  // cycle boundaries seen on the bus
  assign cyc_start = tx_cycle_start_sent || rx_cycle_start_rcvd;
  assign cyc_done  = bus_fair_gap && cyc_active_r;

  ////////////////////////////////////////////////////////////////////////////////
  // cycle timer counter
  cycle_time_counter u_counter (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .run         (ctrl_r[CTRL_TMR_EN]),
    .load        (wr_timer),
    .load_val    (reg_wdata),
    .value       (timer_val),
    .sec_inc     (sec_inc),
    .offset_wrap (offset_wrap),
    .offset_zero (offset_zero)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // general control: timer enable and cycle master
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = reg_wdata[CTRL_W-1:0];
    end
    if (tout_hit) begin
      ctrl_nxt[CTRL_MASTER] = 1'b0; // timeout beats a software write
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // isochronous cycle in progress, from cycle start to fair gap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cyc_active_r <= 1'b0;
    end else if (cyc_start) begin
      cyc_active_r <= 1'b1;
    end else if (bus_fair_gap) begin
      cyc_active_r <= 1'b0;
    end
  end

  // cycle length counter, saturating one past the limit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tout_cnt_r <= '0;
    end else if (cyc_start || !cyc_active_r) begin
      tout_cnt_r <= '0;
    end else if (tout_cnt_r <= tout_limit) begin
      tout_cnt_r <= tout_cnt_r + {{(TOUT_W-1){1'b0}}, 1'b1};
    end
  end

  // the limit is passed exactly once per overlong cycle
  assign tout_hit = cyc_active_r && !cyc_start && !bus_fair_gap && (tout_cnt_r == tout_limit);

  ////////////////////////////////////////////////////////////////////////////////
  // rollovers without a received cycle start while not cycle master
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lost_cnt_r <= 2'h0;
    end else if (rx_cycle_start_rcvd || ctrl_r[CTRL_MASTER] || lost_hit) begin
      lost_cnt_r <= 2'h0;
    end else if (offset_wrap) begin
      lost_cnt_r <= lost_cnt_r + 2'h1;
    end
  end

  assign lost_hit = !ctrl_r[CTRL_MASTER] && !rx_cycle_start_rcvd && offset_wrap
                    && (lost_cnt_r + 2'h1 == LOST_WRAPS);

  ////////////////////////////////////////////////////////////////////////////////
  // hardware events feeding the flags
  always_comb begin
    evt_set                = '0;
    evt_set[EVT_BUSY_ACK]  = rx_busy_ack_sent;
    evt_set[EVT_HDR_ERR]   = rx_header_crc_err;
    evt_set[EVT_TCODE_ERR] = tx_tcode_err;
    evt_set[EVT_CYC_TOUT]  = tout_hit;
    evt_set[EVT_SEC_INC]   = sec_inc;
    evt_set[EVT_CYC_START] = cyc_start;
    evt_set[EVT_CYC_DONE]  = cyc_done;
    evt_set[EVT_CYC_LOST]  = lost_hit;
    evt_set[EVT_FAIR_GAP]  = bus_fair_gap;
  end

  // write one to clear; a zero leaves a flag alone, pending is hardware-owned
  always_comb begin
    evt_clr               = wr_ack ? reg_wdata[EVT_W-1:0] : '0;
    evt_clr[EVT_CYC_PEND] = 1'b0;
    flags_nxt             = (flags_r & ~evt_clr) | evt_set; // set beats clear
    if (offset_zero) begin
      flags_nxt[EVT_CYC_PEND] = 1'b1;
    end else if (cyc_done) begin
      flags_nxt[EVT_CYC_PEND] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_r <= EVT_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt enable mirror
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ena_r <= ENA_RESET;
    end else if (wr_ena) begin
      ena_r <= reg_wdata[EVT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_event_irq  <= 1'b0;
      cycle_master_en <= 1'b0;
      cycle_pending   <= 1'b0;
    end else begin
      link_event_irq  <= |(flags_r & ena_r);
      cycle_master_en <= ctrl_r[CTRL_MASTER];
      cycle_pending   <= flags_r[EVT_CYC_PEND];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (addr_hit(reg_addr, OFF_GEN_CTRL)) begin
      reg_rdata <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
    end else if (addr_hit(reg_addr, OFF_EVT_ACK)) begin
      reg_rdata <= {{(DATA_W-EVT_W){1'b0}}, flags_r};
    end else if (addr_hit(reg_addr, OFF_EVT_ENA)) begin
      reg_rdata <= {{(DATA_W-EVT_W){1'b0}}, ena_r};
    end else if (addr_hit(reg_addr, OFF_CYC_TIMER)) begin
      reg_rdata <= timer_val;
    end else begin
      reg_rdata <= 32'h0000_0000; // unmapped
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_overrun;
    cyc_active_r && !cyc_start && !bus_fair_gap && tout_cnt_r == tout_limit;
  endsequence

  sequence s_master_dropped;
    flags_r[EVT_CYC_TOUT] && !ctrl_r[CTRL_MASTER] ##1 !cycle_master_en;
  endsequence

  sequence s_second_wrap;
    !ctrl_r[CTRL_MASTER] && !rx_cycle_start_rcvd && offset_wrap && lost_cnt_r == 2'h1;
  endsequence

  a_busy_flag_set: assert property (rx_busy_ack_sent |=> flags_r[EVT_BUSY_ACK])
    else $error("busy-sent flag not set");
  a_hdr_flag_set: assert property (rx_header_crc_err |=> flags_r[EVT_HDR_ERR])
    else $error("header error flag not set");
  a_tcode_flag_set: assert property (tx_tcode_err |=> flags_r[EVT_TCODE_ERR])
    else $error("transaction code flag not set");
  a_timeout_master_off: assert property (s_overrun |=> s_master_dropped)
    else $error("cycle timeout did not flag or drop cycle master");
  a_seconds_flag: assert property (sec_inc |-> $changed(timer_val[SEC_HI:SEC_LO]) ##1 flags_r[EVT_SEC_INC])
    else $error("seconds flag or field wrong");
  a_start_flag_set: assert property (cyc_start |=> flags_r[EVT_CYC_START] && cyc_active_r)
    else $error("cycle started flag not set");
  a_done_zero_write: assert property (flags_r[EVT_CYC_DONE] && wr_ack && !reg_wdata[EVT_CYC_DONE]
                                      |=> flags_r[EVT_CYC_DONE])
    else $error("zero write altered cycle done");
  a_pending_holds: assert property (flags_r[EVT_CYC_PEND] && !cyc_done |=> flags_r[EVT_CYC_PEND] ##1 cycle_pending)
    else $error("cycle pending dropped before cycle end");
  a_cycle_lost_set: assert property (s_second_wrap |=> flags_r[EVT_CYC_LOST] && lost_cnt_r == 2'h0)
    else $error("cycle lost flag not set on second rollover");
  a_irq_gating: assert property ((flags_r & ena_r) == '0 ##1 (flags_r & ena_r) == '0 |=> !link_event_irq)
    else $error("interrupt raised with no enabled flag");
  a_enable_mirror: assert property (wr_ena |=> ena_r == $past(reg_wdata[EVT_W-1:0]))
    else $error("enable register not written");

  ////////////////////////////////////////////////////////////////////////////////
  // further checks: flags against their causes, enables, read data
  sequence s_cycle_closed;
    cyc_active_r && bus_fair_gap && !cyc_start;
  endsequence

  sequence s_done_seen;
    flags_r[EVT_CYC_DONE] && !cyc_active_r;
  endsequence

  sequence s_ack_read;
    reg_rd && addr_hit(reg_addr, OFF_EVT_ACK);
  endsequence

  sequence s_timer_read;
    reg_rd && addr_hit(reg_addr, OFF_CYC_TIMER);
  endsequence

  // event flags, pending and lost count
  a_fair_gap_flag: assert property (bus_fair_gap |=> flags_r[EVT_FAIR_GAP])
    else $error("fair gap flag not set");
  a_done_flag_set: assert property (s_cycle_closed |=> s_done_seen)
    else $error("cycle done flag not set at cycle end");
  a_pending_set: assert property (offset_zero |=> flags_r[EVT_CYC_PEND])
    else $error("cycle pending not raised at zero offset");
  a_flags_sticky: assert property (!wr_ack && !cyc_done |=> ($past(flags_r) & ~flags_r) == '0)
    else $error("flag cleared without a write");
  a_tout_restart: assert property (cyc_start |=> tout_cnt_r == '0)
    else $error("cycle length count not restarted");
  a_tout_flag_cause: assert property (!flags_r[EVT_CYC_TOUT] && !tout_hit |=> !flags_r[EVT_CYC_TOUT])
    else $error("timeout flag set without overrun");
  a_lost_master_quiet: assert property (ctrl_r[CTRL_MASTER] |=> lost_cnt_r == 2'h0)
    else $error("lost count ran while cycle master");
  a_lost_needs_wrap: assert property (!offset_wrap |=> lost_cnt_r == $past(lost_cnt_r) || lost_cnt_r == 2'h0)
    else $error("lost count moved without a rollover");
  a_lost_flag_cause: assert property (!flags_r[EVT_CYC_LOST] && !lost_hit |=> !flags_r[EVT_CYC_LOST])
    else $error("cycle lost flag set without second rollover");

  // enables and interrupt output
  a_enable_holds: assert property (!wr_ena |=> $stable(ena_r))
    else $error("enable register changed without a write");
  a_irq_raised: assert property ((flags_r & ena_r) != '0 |=> link_event_irq)
    else $error("enabled flag raised no interrupt");

  // read data answer the state at the strobe edge
  a_ack_rd: assert property (s_ack_read |=> reg_rdata[EVT_W-1:0] == $past(flags_r))
    else $error("acknowledge read returned wrong flags");
  a_timer_rd: assert property (s_timer_read |=> reg_rdata == $past(timer_val))
    else $error("timer read returned wrong value");

endmodule

`default_nettype wire

// ### link_phy_model.sv
/*
  Far-side model: the physical layer and bus as seen by the link event logic,
  sending one-cycle event pulses on request.
  Assumes the bench raises ev_go for one ref_clk cycle per event.
*/
`default_nettype none

module link_phy_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ev_go,
  input  wire logic [2:0] ev_sel,
  output logic            rx_busy_ack_sent,
  output logic            rx_header_crc_err,
  output logic            tx_tcode_err,
  output logic            tx_cycle_start_sent,
  output logic            rx_cycle_start_rcvd,
  output logic            bus_fair_gap
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] pulse_r;

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle pulse on the selected event line, quiet otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      pulse_r <= 6'h00;
    else
      pulse_r <= ev_go ? (6'h01 << ev_sel) : 6'h00;
  end

  // event lines in selector order
  assign rx_busy_ack_sent    = pulse_r[0];
  assign rx_header_crc_err   = pulse_r[1];
  assign tx_tcode_err        = pulse_r[2];
  assign tx_cycle_start_sent = pulse_r[3];
  assign rx_cycle_start_rcvd = pulse_r[4];
  assign bus_fair_gap        = pulse_r[5];

endmodule

`default_nettype wire

// ### link_cycle_timer_and_events_tb.sv
/*
  Self-checking bench for the link cycle timer and event flags.
  Assumes a 50 MHz ref_clk and the far-side pulse model link_phy_model.
*/
`default_nettype none

module link_cycle_timer_and_events_tb
  import cycle_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TMO = 40;
  localparam int          LIMIT = 20000;

  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        ev_go;
  logic [2:0]  ev_sel;
  logic        busy_ack, hdr_err, tcode_err, cs_sent, cs_rcvd, fair_gap;
  logic        link_event_irq;
  logic        cycle_master_en;
  logic        cycle_pending;
  logic [31:0] d;
  logic [31:0] d2;
  int          error_cnt;
  int          n_compared;
  int          cyc_cnt;

  link_cycle_timer_and_events #(.TIMEOUT_CYCLES(TMO)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_busy_ack_sent(busy_ack), .rx_header_crc_err(hdr_err), .tx_tcode_err(tcode_err),
    .tx_cycle_start_sent(cs_sent), .rx_cycle_start_rcvd(cs_rcvd), .bus_fair_gap(fair_gap),
    .link_event_irq(link_event_irq), .cycle_master_en(cycle_master_en), .cycle_pending(cycle_pending)
  );

  link_phy_model u_phy (
    .ref_clk(ref_clk), .rst_n(rst_n), .ev_go(ev_go), .ev_sel(ev_sel),
    .rx_busy_ack_sent(busy_ack), .rx_header_crc_err(hdr_err), .tx_tcode_err(tcode_err),
    .tx_cycle_start_sent(cs_sent), .rx_cycle_start_rcvd(cs_rcvd), .bus_fair_gap(fair_gap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      $display("MISMATCH %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // access tasks and comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask

  // one event pulse from the far side
  task automatic fire(input logic [2:0] s);
    @(posedge ref_clk);
    ev_go  <= 1'b1;
    ev_sel <= s;
    @(posedge ref_clk);
    ev_go <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic ack_bit(input int unsigned b, input logic v, input string msg);
    reg_read(OFF_EVT_ACK, d);
    chk({31'h0, d[b]}, {31'h0, v}, msg);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int unsigned eb [3];
    eb = '{EVT_BUSY_ACK, EVT_HDR_ERR, EVT_TCODE_ERR};
    rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    ev_go = 1'b0; ev_sel = 3'h0; error_cnt = 0; n_compared = 0; cyc_cnt = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values and register map
    reg_read(OFF_EVT_ENA, d);
    chk(d, 32'h0000_0000, "enable reset");
    reg_read(OFF_CYC_TIMER, d);
    chk(d, 32'h0000_0000, "timer reset");
    chk({31'h0, cycle_pending}, 32'h1, "pending from reset");
    reg_write(OFF_EVT_ENA, 32'hFFFF_FFFF);
    reg_read(OFF_EVT_ENA, d);
    chk(d, 32'h0007_FFFF, "enable width");
    reg_read(8'h04, d);
    chk(d, 32'h0000_0000, "unmapped read");
    $display("test reset_map done");
    // error flags: recorded while masked, interrupt once enabled
    for (int i = 0; i < 3; i++) begin
      reg_write(OFF_EVT_ENA, 32'h0);
      reg_write(OFF_EVT_ACK, 32'h0007_FFFF);
      fire(3'(i));
      ack_bit(eb[i], 1'b1, "error flag");
      chk({31'h0, link_event_irq}, 32'h0, "masked irq");
      reg_write(OFF_EVT_ENA, 32'h1 << eb[i]);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, link_event_irq}, 32'h1, "enabled irq");
      reg_write(OFF_EVT_ACK, 32'h1 << eb[i]);
      ack_bit(eb[i], 1'b0, "flag cleared");
    end
    reg_write(OFF_EVT_ENA, 32'h0);
    $display("test error_flags done");
    // received cycle start then fair gap
    reg_write(OFF_EVT_ACK, 32'h0007_FFFF);
    fire(3'd4);
    ack_bit(EVT_CYC_START, 1'b1, "cycle start rx");
    fire(3'd5);
    ack_bit(EVT_CYC_DONE, 1'b1, "cycle done");
    ack_bit(EVT_FAIR_GAP, 1'b1, "fair gap");
    chk({31'h0, cycle_pending}, 32'h0, "pending ends");
    reg_write(OFF_EVT_ACK, 32'h0);
    ack_bit(EVT_CYC_DONE, 1'b1, "write zero keeps");
    $display("test cycle_events done");
    // timer fields, rate, stop and wrap
    reg_write(OFF_CYC_TIMER, 32'h0123_4567);
    reg_read(OFF_CYC_TIMER, d);
    chk(d, 32'h0123_4567, "timer load");
    reg_write(OFF_CYC_TIMER, 32'h0);
    reg_write(OFF_GEN_CTRL, 32'h1);
    reg_read(OFF_CYC_TIMER, d);
    repeat (97) @(posedge ref_clk);
    reg_read(OFF_CYC_TIMER, d2);
    chk(d2 - d, 32'h32, "tick rate");
    reg_write(OFF_GEN_CTRL, 32'h0);
    reg_read(OFF_CYC_TIMER, d);
    repeat (20) @(posedge ref_clk);
    reg_read(OFF_CYC_TIMER, d2);
    chk(d2, d, "timer stopped");
    reg_write(OFF_CYC_TIMER, 32'h01F3_FBFF);
    fire(3'd4);
    fire(3'd5);
    reg_write(OFF_EVT_ACK, 32'h0007_FFFF);
    chk({31'h0, cycle_pending}, 32'h0, "pending cleared before wrap");
    reg_write(OFF_GEN_CTRL, 32'h1);
    repeat (10) @(posedge ref_clk);
    reg_read(OFF_CYC_TIMER, d);
    chk(d & 32'hFFFF_F000, 32'h0200_0000, "carry to seconds");
    chk({31'h0, d[11:4] == 8'h00}, 32'h1, "offset restarted");
    ack_bit(EVT_SEC_INC, 1'b1, "seconds flag");
    chk({31'h0, cycle_pending}, 32'h1, "pending on wrap");
    $display("test cycle_timer done");
    // cycle master timeout after a sent cycle start
    reg_write(OFF_GEN_CTRL, 32'h2);
    reg_write(OFF_EVT_ACK, 32'h0007_FFFF);
    chk({31'h0, cycle_master_en}, 32'h1, "master on");
    fire(3'd3);
    repeat (TMO + 10) @(posedge ref_clk);
    chk({31'h0, cycle_master_en}, 32'h0, "master dropped");
    ack_bit(EVT_CYC_TOUT, 1'b1, "timeout flag");
    ack_bit(EVT_CYC_START, 1'b1, "cycle start tx");
    reg_read(OFF_GEN_CTRL, d);
    chk(d, 32'h0000_0000, "control after timeout");
    $display("test cycle_timeout done");
    // two wraps with no received cycle start
    reg_write(OFF_CYC_TIMER, 32'h0000_0BFF);
    reg_write(OFF_GEN_CTRL, 32'h1);
    reg_write(OFF_EVT_ACK, 32'h0007_FFFF);
    repeat (100) @(posedge ref_clk);
    ack_bit(EVT_CYC_LOST, 1'b0, "one wrap only");
    repeat (6200) @(posedge ref_clk);
    ack_bit(EVT_CYC_LOST, 1'b1, "cycle lost");
    $display("test cycle_lost done");
    tally_and_finish();
  end

endmodule

`default_nettype wire
